/* File: hdl/qpc_pkg.sv */
// constants shared by the quad pulse counter design files
package qpc_pkg;

	// register bus geometry
	localparam int          ADDR_W        = 8;
	localparam int          DATA_W        = 16;
	localparam int          NCH           = 4;

	// word offsets on the register port
	localparam logic [7:0]  OFS_STATUS    = 8'h00;
	localparam logic [7:0]  OFS_ERRORS    = 8'h01;
	localparam logic [7:0]  OFS_COUNT0    = 8'h02;
	localparam logic [7:0]  OFS_COUNT3    = 8'h05;
	localparam logic [7:0]  OFS_MODE0     = 8'h08;
	localparam logic [7:0]  OFS_MODE3     = 8'h0B;
	localparam logic [7:0]  OFS_TARGET0   = 8'h0C;
	localparam logic [7:0]  OFS_TARGET3   = 8'h0F;
	localparam logic [7:0]  OFS_IRQ_STAT  = 8'h10;
	localparam logic [7:0]  OFS_IRQ_MASK  = 8'h11;

	// mode word fields
	localparam int          MB_DOWN       = 0;
	localparam int          MB_REPEAT     = 1;
	localparam int          MB_DIFF       = 2;
	localparam int          MB_FAST       = 3;
	localparam int          MB_CHANGE     = 8;

	// status word fields
	localparam int          SB_READY      = 0;
	localparam int          SB_FAULT      = 1;
	localparam int          SB_OUT_LSB    = 4;
	localparam int          SB_GATE_LSB   = 8;
	localparam int          SB_TRIP_LSB   = 12;

	// interrupt status fields: bits 3:0 target reached, bit 4 trip
	localparam int          IB_TRIP       = 4;
	localparam int          IRQ_W         = 5;

	// configuration error codes
	localparam logic [3:0]  ERR_NONE      = 4'h0;
	localparam logic [3:0]  ERR_DIFF_FAST = 4'h1;
	localparam logic [3:0]  ERR_DIFF_REP  = 4'h2;
	localparam logic [3:0]  ERR_FAST_CH   = 4'h3;
	localparam logic [3:0]  ERR_SLAVE_CHG = 4'h4;
	localparam logic [3:0]  ERR_DIFF_CH   = 4'h5;
	localparam logic [3:0]  ERR_TARGET    = 4'h6;

	// reset values
	localparam logic [15:0] RST_WORD      = 16'h0000;
	localparam logic [4:0]  RST_IRQ       = 5'h00;

	// timing: input filters hold for half of the fastest legal period
	localparam int          CLK_PERIOD_NS = 50;
	localparam int          PER_NORMAL_NS = 1_000_000;
	localparam int          PER_FAST_NS   = 100_000;
	localparam int          FILT_NORMAL   = PER_NORMAL_NS / CLK_PERIOD_NS / 2;
	localparam int          FILT_FAST     = PER_FAST_NS / CLK_PERIOD_NS / 2;
	localparam logic [4:0]  INIT_CYCLES   = 5'h10;

endpackage

/* File: hdl/qpc_in_filter.sv */
// input synchroniser, stability filter and rising edge detector
`timescale 1ns/1ps
module qpc_in_filter (
	// clock and reset
	input  wire logic        i_sys_clk,
	input  wire logic        i_reset,
	// raw pin and filter length
	input  wire logic        i_raw,
	input  wire logic [15:0] i_limit,
	// one cycle pulse on an accepted rising edge
	output logic             o_rise
);
	typedef struct packed {
		logic        s1;
		logic        s2;
		logic        level;
		logic [15:0] cnt;
		logic        rise;
	} qpc_filt_t;

	qpc_filt_t q;
	qpc_filt_t n;

	// two stage sync, then a level must stand i_limit cycles to be taken
	always_comb begin
		n = q;
		n.s1 = i_raw;
		n.s2 = q.s1;
		n.rise = 1'b0;
		if (q.s2 != q.level) begin
			n.cnt = q.cnt + 16'h0001;
			if (n.cnt >= i_limit) begin
				n.level = q.s2;
				n.cnt = 16'h0000;
				n.rise = q.s2;
			end
		end else begin
			n.cnt = 16'h0000;
		end
	end

	// state register
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign o_rise = q.rise;
endmodule

/* File: hdl/qpc_counter_top.sv */
// four channel 16-bit pulse counter with register port and protection
//
// Contract
// - four independent 16-bit counters, each taking pulses up to 1 kHz
// - channel 1 may be set to take pulses up to 10 kHz
// - each counter spans 0 to 65535 accumulated pulses and wraps, short of the top of the fifth decade
// - each counter works as event or repeat counter; channels 1 and 3 also as differential counter
// - alone, a channel counts up or down, once or repetitively
// - channels 1/2 and 3/4 may join into one shared differential count
// - in a pair the lower input adds, the higher input subtracts
// - the pair's count reads in the first channel's count word
// - output on when up count hits target or down count reaches zero
// - pulses count only while that channel's gate input is high
// - overloaded outputs switch off and a common fault flag is raised
// - a tripped output stays off until the manual reset input
// - ready only after internal start-up and with the host running
// - per channel indications of output on and gate high
// - six status and count words in, one setup path out
// - one 4-bit error code per channel in the second status word
`timescale 1ns/1ps
module qpc_counter_top #(
	parameter logic [15:0] P_FILT_NORMAL = 16'(qpc_pkg::FILT_NORMAL)
) (
	// clock and reset
	input  wire logic                        i_sys_clk,
	input  wire logic                        i_reset,
	// register port
	input  wire logic [qpc_pkg::ADDR_W-1:0]  i_addr,
	input  wire logic [qpc_pkg::DATA_W-1:0]  i_wdata,
	input  wire logic                        i_wr,
	input  wire logic                        i_rd,
	output logic      [qpc_pkg::DATA_W-1:0]  o_rdata,
	// field inputs
	input  wire logic [qpc_pkg::NCH-1:0]     i_pulse,
	input  wire logic [qpc_pkg::NCH-1:0]     i_gate,
	input  wire logic [qpc_pkg::NCH-1:0]     i_out_fault,
	input  wire logic                        i_manual_reset,
	input  wire logic                        i_host_run,
	// field outputs and indicators
	output logic      [qpc_pkg::NCH-1:0]     o_target_out,
	output logic      [qpc_pkg::NCH-1:0]     o_out_led,
	output logic      [qpc_pkg::NCH-1:0]     o_gate_led,
	output logic                             o_fault_led,
	output logic                             o_ready,
	output logic                             o_irq
);
	import qpc_pkg::*;

	typedef struct packed {
		logic                  down;
		logic                  rep;
		logic                  diff;
		logic                  fast;
	} qpc_cfg_t;

	// whole block state; counts are 16 bits and wrap past 16'hFFFF, so
	// the top of the fifth decade is out of reach without host tracking
	typedef struct packed {
		logic [NCH-1:0]        gate_s1;
		logic [NCH-1:0]        gate_s2;
		logic [NCH-1:0][15:0]  mode;
		logic [NCH-1:0][15:0]  target;
		qpc_cfg_t [NCH-1:0]    cfg;
		logic [NCH-1:0][15:0]  count;
		logic [NCH-1:0]        done;
		logic [NCH-1:0]        hit;
		logic [NCH-1:0]        trip;
		logic [NCH-1:0]        pin;
		logic [15:0]           err;
		logic [4:0]            init_cnt;
		logic                  init_done;
		logic                  ready;
		logic                  fault;
		logic [IRQ_W-1:0]      irq_st;
		logic [IRQ_W-1:0]      irq_mask;
		logic                  irq;
		logic [15:0]           rdata;
	} qpc_state_t;

	qpc_state_t q;
	qpc_state_t n;

	logic [NCH-1:0]        rise;
	logic [NCH-1:0][15:0]  limit;

	// filter length per channel; only channel 1 may run fast
	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			limit[i] = P_FILT_NORMAL;
		end
		if (q.cfg[0].fast) begin
			limit[0] = 16'(FILT_FAST);
		end
	end

	// one synchronising edge filter per pulse input
	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_in
			qpc_in_filter u_filt (
				.i_sys_clk (i_sys_clk),
				.i_reset   (i_reset),
				.i_raw     (i_pulse[g]),
				.i_limit   (limit[g]),
				.o_rise    (rise[g])
			);
		end
	endgenerate

	// check a requested mode word for channel ch against the active setup
	function automatic logic [3:0] check_mode(
		input int          ch,
		input logic [15:0] mw,
		input logic [15:0] tgt,
		input qpc_cfg_t    lead
	);
		logic [3:0] code;
		code = ERR_NONE;
		// codes in order of precedence: fast with differential on channel 1,
		// differential with repeat, fast off channel 1, a change on a
		// follower whose leader is differential, differential on a
		// follower, and a zero target
		if (ch == 0 && mw[MB_DIFF] && mw[MB_FAST]) begin
			code = ERR_DIFF_FAST;
		end else if (ch[0] == 1'b0 && mw[MB_DIFF] && mw[MB_REPEAT]) begin
			code = ERR_DIFF_REP;
		end else if (ch != 0 && mw[MB_FAST]) begin
			code = ERR_FAST_CH;
		end else if (ch[0] == 1'b1 && lead.diff) begin
			code = ERR_SLAVE_CHG;
		end else if (ch[0] == 1'b1 && mw[MB_DIFF]) begin
			code = ERR_DIFF_CH;
		end else if (tgt == RST_WORD) begin
			code = ERR_TARGET;
		end
		return code;
	endfunction

	// count a channel starts from: a lone down counter starts at its target
	function automatic logic [15:0] start_count(
		input logic [15:0] mw,
		input logic [15:0] tgt
	);
		logic [15:0] val;
		val = RST_WORD;
		if (mw[MB_DOWN] && !mw[MB_DIFF]) begin
			val = tgt;
		end
		return val;
	endfunction

	// next state of the whole block
	always_comb begin
		logic [NCH-1:0] en;
		logic [NCH-1:0] slave;
		logic [15:0]    c;
		logic [3:0]     code;
		logic [1:0]     idx;
		logic [1:0]     mate;
		logic           up;
		logic           dn;
		logic [IRQ_W-1:0] ev;
		en = '0;
		slave = '0;
		c = RST_WORD;
		code = ERR_NONE;
		idx = 2'd0;
		mate = 2'd0;
		up = 1'b0;
		dn = 1'b0;
		ev = '0;
		n = q;

		// gate synchronisers and start-up sequencing
		// start-up counts INIT_CYCLES clocks, then ready follows the host
		n.gate_s1 = i_gate;
		n.gate_s2 = q.gate_s1;
		if (!q.init_done) begin
			n.init_cnt = q.init_cnt + 5'h01;
			n.init_done = (n.init_cnt == INIT_CYCLES);
		end
		n.ready = q.init_done && i_host_run;

		// enabled pulses and differential followers
		for (int i = 0; i < NCH; i++) begin
			en[i] = rise[i] && q.gate_s2[i];
			slave[i] = (i % 2 == 1) && q.cfg[i - (i % 2)].diff;
		end

		// counting per channel: a pair leader follows both inputs, a
		// follower reads zero, and a lone channel stops at its end point
		// unless it repeats
		for (int i = 0; i < NCH; i++) begin
			// a pair counts in its lower channel; pulses on both cancel
			if (q.cfg[i].diff && !slave[i] && i % 2 == 0) begin
				up = en[i];
				dn = en[i ^ 1];
				c = q.count[i];
				if (up && !dn) begin
					c = q.count[i] + 16'h0001;
				end else if (dn && !up) begin
					c = q.count[i] - 16'h0001;
				end
				n.count[i] = c;
				n.hit[i] = (c == q.target[i]);
			end else if (slave[i]) begin
				n.count[i] = RST_WORD;
				n.hit[i] = 1'b0;
			end else if (en[i] && !q.done[i]) begin
				if (q.hit[i] && q.cfg[i].rep) begin
					n.hit[i] = 1'b0; // repeat output drops on the next pulse
				end
				if (!q.cfg[i].down) begin
					c = q.count[i] + 16'h0001;
					if (c == q.target[i]) begin
						n.hit[i] = 1'b1;
						n.count[i] = q.cfg[i].rep ? RST_WORD : c;
						n.done[i] = !q.cfg[i].rep;
					end else begin
						n.count[i] = c;
					end
				end else begin
					c = q.count[i] - 16'h0001;
					if (c == RST_WORD) begin
						n.hit[i] = 1'b1;
						n.count[i] = q.cfg[i].rep ? q.target[i] : c;
						n.done[i] = !q.cfg[i].rep;
					end else begin
						n.count[i] = c;
					end
				end
			end
		end

		// output protection: fault sets the trip, manual reset clears it
		for (int i = 0; i < NCH; i++) begin
			if (i_out_fault[i]) begin
				n.trip[i] = 1'b1;
			end else if (i_manual_reset) begin
				n.trip[i] = 1'b0;
			end
			n.pin[i] = n.hit[i] && !n.trip[i];
			ev[i] = n.hit[i] && !q.hit[i];
		end
		n.fault = |n.trip;
		ev[IB_TRIP] = |(n.trip & ~q.trip);

		// register writes; bit 8 rising in a mode word applies the setup, so
		// a host that leaves bit 8 set cannot apply twice by accident
		if (i_wr) begin
			idx = i_addr[1:0];
			mate = {i_addr[1], 1'b1};
			if (i_addr >= OFS_MODE0 && i_addr <= OFS_MODE3) begin
				n.mode[idx] = i_wdata;
				if (i_wdata[MB_CHANGE] && !q.mode[idx][MB_CHANGE]) begin
					code = check_mode(int'(idx), i_wdata, q.target[idx],
						q.cfg[{idx[1], 1'b0}]);
					n.err[idx*4 +: 4] = code;
					if (code == ERR_NONE) begin
						// a good setup restarts the channel
						n.cfg[idx].down = i_wdata[MB_DOWN];
						n.cfg[idx].rep = i_wdata[MB_REPEAT];
						n.cfg[idx].diff = i_wdata[MB_DIFF];
						n.cfg[idx].fast = i_wdata[MB_FAST];
						n.count[idx] = start_count(i_wdata, q.target[idx]);
						n.done[idx] = 1'b0;
						n.hit[idx] = 1'b0;
						n.pin[idx] = 1'b0;
						if (i_wdata[MB_DIFF]) begin
							n.count[idx + 2'd1] = RST_WORD;
							n.done[idx + 2'd1] = 1'b0;
							n.hit[idx + 2'd1] = 1'b0;
							n.pin[idx + 2'd1] = 1'b0;
						end
						// leaving differential frees the follower again
						if (!i_wdata[MB_DIFF] && q.cfg[idx].diff) begin
							n.count[mate] = q.cfg[mate].down
								? q.target[mate] : RST_WORD;
							n.done[mate] = 1'b0;
							n.hit[mate] = 1'b0;
							n.pin[mate] = 1'b0;
						end
					end
				end
			end else if (i_addr >= OFS_TARGET0 && i_addr <= OFS_TARGET3) begin
				n.target[idx] = i_wdata;
			end else if (i_addr == OFS_IRQ_STAT) begin
				n.irq_st = q.irq_st & ~i_wdata[IRQ_W-1:0];
			end else if (i_addr == OFS_IRQ_MASK) begin
				n.irq_mask = i_wdata[IRQ_W-1:0];
			end
		end
		// new events win over a clear in the same cycle
		n.irq_st = n.irq_st | ev;
		n.irq = |(n.irq_st & n.irq_mask);

		// read data, valid in the cycle after the read strobe
		// unmapped words and idle cycles read as zero
		n.rdata = RST_WORD;
		if (i_rd) begin
			if (i_addr == OFS_STATUS) begin
				n.rdata[SB_READY] = q.ready;
				n.rdata[SB_FAULT] = q.fault;
				n.rdata[SB_OUT_LSB +: NCH] = q.pin;
				n.rdata[SB_GATE_LSB +: NCH] = q.gate_s2;
				n.rdata[SB_TRIP_LSB +: NCH] = q.trip;
			end else if (i_addr == OFS_ERRORS) begin
				n.rdata = q.err;
			end else if (i_addr >= OFS_COUNT0 && i_addr <= OFS_COUNT3) begin
				n.rdata = q.count[2'(i_addr - OFS_COUNT0)];
			end else if (i_addr >= OFS_MODE0 && i_addr <= OFS_MODE3) begin
				n.rdata = q.mode[i_addr[1:0]];
			end else if (i_addr >= OFS_TARGET0 && i_addr <= OFS_TARGET3) begin
				n.rdata = q.target[i_addr[1:0]];
			end else if (i_addr == OFS_IRQ_STAT) begin
				n.rdata[IRQ_W-1:0] = q.irq_st;
			end else if (i_addr == OFS_IRQ_MASK) begin
				n.rdata[IRQ_W-1:0] = q.irq_mask;
			end
		end
	end

	// state register
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	// outputs straight from flip-flops
	assign o_rdata      = q.rdata;
	assign o_target_out = q.pin;
	assign o_out_led    = q.pin;
	assign o_gate_led   = q.gate_s2;
	assign o_fault_led  = q.fault;
	assign o_ready      = q.ready;
	assign o_irq        = q.irq;
endmodule

/* File: verif/qpc_counter_top_sva.sv */
// port assertions for the quad pulse counter
`timescale 1ns/1ps
module qpc_counter_top_sva #(
	parameter logic [15:0] P_FILT_NORMAL = 16'(qpc_pkg::FILT_NORMAL)
) (
	// clock and reset
	input wire logic        i_sys_clk,
	input wire logic        i_reset,
	// register port
	input wire logic [7:0]  i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic        i_wr,
	input wire logic        i_rd,
	input wire logic [15:0] o_rdata,
	// field side
	input wire logic [3:0]  i_pulse,
	input wire logic [3:0]  i_gate,
	input wire logic [3:0]  i_out_fault,
	input wire logic        i_manual_reset,
	input wire logic        i_host_run,
	input wire logic [3:0]  o_target_out,
	input wire logic [3:0]  o_out_led,
	input wire logic [3:0]  o_gate_led,
	input wire logic        o_fault_led,
	input wire logic        o_ready,
	input wire logic        o_irq
);
	import qpc_pkg::*;
	default clocking dc @(posedge i_sys_clk); endclocking
	default disable iff (i_reset);
	// indications and protection
	chk_led_mirror: assert property (o_out_led == o_target_out)
		else $error("output lamps differ from outputs");
	chk_gate_led: assert property (
		$stable(i_gate) [*4] |-> o_gate_led == i_gate)
		else $error("gate lamps do not follow gates");
	chk_fault_flag: assert property (
		|i_out_fault |-> ##[1:2] o_fault_led)
		else $error("fault lamp not raised");
	chk_trip_off: assert property (
		|i_out_fault |-> ##2 (o_target_out & $past(i_out_fault, 2)) == 4'h0)
		else $error("faulted output still on");
	chk_trip_hold: assert property (
		o_fault_led && !i_manual_reset && !$past(i_manual_reset)
		|=> o_fault_led)
		else $error("trip cleared without manual reset");
	chk_ready_host: assert property (!i_host_run |=> !o_ready)
		else $error("ready while host stopped");
	// register port answers
	chk_rdata_idle: assert property (!i_rd |=> o_rdata == 16'h0000)
		else $error("read data outside its cycle");
	chk_unmapped_rd: assert property (
		i_rd && (i_addr > OFS_IRQ_MASK || i_addr inside {8'h06, 8'h07})
		|=> o_rdata == 16'h0000)
		else $error("unmapped read not zero");
	// main scenarios reached
	cover property ($rose(o_ready));
	cover property ($rose(o_fault_led));
	cover property ($rose(o_irq));
endmodule
bind qpc_counter_top qpc_counter_top_sva #(.P_FILT_NORMAL(P_FILT_NORMAL))
	qpc_counter_top_sva_i (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
	.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
	.o_rdata(o_rdata), .i_pulse(i_pulse), .i_gate(i_gate),
	.i_out_fault(i_out_fault), .i_manual_reset(i_manual_reset),
	.i_host_run(i_host_run), .o_target_out(o_target_out),
	.o_out_led(o_out_led), .o_gate_led(o_gate_led),
	.o_fault_led(o_fault_led), .o_ready(o_ready), .o_irq(o_irq));

/* File: verif/qpc_host_model.sv */
// host controller model speaking the register port
`timescale 1ns/1ps
module qpc_host_model (
	// clock
	input  wire logic        i_sys_clk,
	// register port towards the counter
	input  wire logic [15:0] i_rdata,
	output logic      [7:0]  o_addr,
	output logic      [15:0] o_wdata,
	output logic             o_wr,
	output logic             o_rd
);
	import qpc_pkg::*;
	// idle bus at time zero
	initial begin
		o_addr = 8'h00;
		o_wdata = 16'h0000;
		o_wr = 1'b0;
		o_rd = 1'b0;
	end
	// one write; released lines show inverted data, never the old value
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge i_sys_clk);
		o_addr <= a;
		o_wdata <= d;
		o_wr <= 1'b1;
		@(posedge i_sys_clk);
		o_wr <= 1'b0;
		o_addr <= ~a;
		o_wdata <= ~d;
	endtask
	// one read; data taken in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge i_sys_clk);
		o_addr <= a;
		o_rd <= 1'b1;
		@(posedge i_sys_clk);
		o_rd <= 1'b0;
		o_addr <= ~a;
		#1;
		d = i_rdata;
	endtask
	// target first, then the mode with the change flag for one write
	task automatic apply(input int ch, input logic [15:0] m, t);
		wr(OFS_TARGET0 + 8'(ch), t);
		wr(OFS_MODE0 + 8'(ch), m | 16'h0100);
		wr(OFS_MODE0 + 8'(ch), m);
	endtask
endmodule

/* File: verif/test_quad_channel_pulse_counter.sv */
// self-checking bench for the quad pulse counter
`timescale 1ns/1ps
module test_quad_channel_pulse_counter;
	import qpc_pkg::*;
	localparam logic [15:0] FL = 16'h0008;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  addr;
	logic [15:0] wdata;
	logic        wr;
	logic        rd;
	logic [15:0] rdata;
	logic [3:0]  pulse = 4'h0;
	logic [3:0]  gate = 4'h0;
	logic [3:0]  flt = 4'h0;
	logic        mrst = 1'b0;
	logic        run = 1'b0;
	logic [3:0]  tout;
	logic [3:0]  gled;
	logic        fled;
	logic        rdy;
	logic        irq;
	int          err_count = 0;
	int          cmp_count = 0;
	// host model and block under test
	qpc_host_model qpc_host_model_i (.i_sys_clk(clk), .i_rdata(rdata),
		.o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
	qpc_counter_top #(.P_FILT_NORMAL(FL)) qpc_counter_top_i (
		.i_sys_clk(clk), .i_reset(rst), .i_addr(addr), .i_wdata(wdata),
		.i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_pulse(pulse),
		.i_gate(gate), .i_out_fault(flt), .i_manual_reset(mrst),
		.i_host_run(run), .o_target_out(tout), .o_out_led(),
		.o_gate_led(gled), .o_fault_led(fled), .o_ready(rdy), .o_irq(irq));
	// 20 MHz clock
	initial begin
		forever #25 clk = ~clk;
	end
	task automatic chk(input logic [15:0] got, exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
		logic [15:0] d;
		qpc_host_model_i.rd(a, d);
		chk(d, exp);
	endtask
	// wait edges, then step past them so outputs have settled
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// n full pulses, each phase w cycles; the default beats the normal filter
	task automatic pls(input int ch, input int n, input int w = FL + 6);
		repeat (n) begin
			@(posedge clk) pulse[ch] <= 1'b1;
			repeat (w) @(posedge clk);
			pulse[ch] <= 1'b0;
			repeat (w) @(posedge clk);
		end
	endtask
	task automatic t_ready();
		wt(30);
		chk({15'h0, rdy}, 16'h0000);
		@(posedge clk) run <= 1'b1;
		for (int i = 0; i < 30 && rdy !== 1'b1; i++) wt(1);
		chk({15'h0, rdy}, 16'h0001);
		rdchk(OFS_STATUS, 16'h0001);
		rdchk(OFS_ERRORS, RST_WORD);
		rdchk(OFS_IRQ_MASK, RST_WORD);
		rdchk(8'h07, 16'h0000);
	endtask
	task automatic t_up_once();
		qpc_host_model_i.apply(0, 16'h0000, 16'h0002);
		pls(0, 1);
		rdchk(OFS_COUNT0, 16'h0000);
		@(posedge clk) gate[0] <= 1'b1;
		pls(0, 3);
		rdchk(OFS_COUNT0, 16'h0002);
		chk({15'h0, tout[0]}, 16'h0001);
		rdchk(OFS_STATUS, 16'h0111);
		rdchk(OFS_IRQ_STAT, 16'h0001);
		qpc_host_model_i.wr(OFS_IRQ_STAT, 16'h0001);
		rdchk(OFS_IRQ_STAT, 16'h0000);
	endtask
	task automatic t_down();
		qpc_host_model_i.apply(1, 16'h0001, 16'h0003);
		rdchk(OFS_COUNT0 + 8'h01, 16'h0003);
		@(posedge clk) gate[1] <= 1'b1;
		pls(1, 3);
		rdchk(OFS_COUNT0 + 8'h01, 16'h0000);
		chk({15'h0, tout[1]}, 16'h0001);
	endtask
	task automatic t_repeat();
		qpc_host_model_i.apply(3, 16'h0002, 16'h0002);
		@(posedge clk) gate[3] <= 1'b1;
		pls(3, 2);
		rdchk(OFS_COUNT3, 16'h0000);
		chk({15'h0, tout[3]}, 16'h0001);
		pls(3, 1);
		rdchk(OFS_COUNT3, 16'h0001);
		chk({15'h0, tout[3]}, 16'h0000);
		qpc_host_model_i.apply(1, 16'h0003, 16'h0002);
		pls(1, 2);
		rdchk(OFS_COUNT0 + 8'h01, 16'h0002);
		chk({15'h0, tout[1]}, 16'h0001);
	endtask
	task automatic t_fast();
		qpc_host_model_i.apply(0, 16'h0008, 16'h0001);
		pls(0, 1);
		rdchk(OFS_COUNT0, 16'h0000);
		pls(0, 1, FILT_FAST + 10);
		rdchk(OFS_COUNT0, 16'h0001);
		chk({15'h0, tout[0]}, 16'h0001);
	endtask
	task automatic t_diff();
		qpc_host_model_i.apply(2, 16'h0004, 16'h0005);
		@(posedge clk) gate[2] <= 1'b1;
		pls(2, 3);
		pls(3, 1);
		rdchk(OFS_COUNT0 + 8'h02, 16'h0002);
		rdchk(OFS_COUNT3, 16'h0000);
		chk({15'h0, gled[2]}, 16'h0001);
	endtask
	task automatic t_fault();
		qpc_host_model_i.wr(OFS_IRQ_MASK, 16'h0010);
		@(posedge clk) flt[0] <= 1'b1;
		mrst <= 1'b1;
		wt(4);
		chk({14'h0, tout[0], fled}, 16'h0001);
		chk({15'h0, irq}, 16'h0001);
		@(posedge clk) flt[0] <= 1'b0;
		mrst <= 1'b0;
		wt(4);
		chk({15'h0, fled}, 16'h0001);
		@(posedge clk) mrst <= 1'b1;
		@(posedge clk) mrst <= 1'b0;
		wt(4);
		chk({14'h0, tout[0], fled}, 16'h0002);
		qpc_host_model_i.wr(OFS_IRQ_STAT, 16'h0010);
		wt(3);
		chk({15'h0, irq}, 16'h0000);
	endtask
	task automatic errchk(input int ch, input logic [15:0] m, t, e);
		qpc_host_model_i.apply(ch, m, t);
		rdchk(OFS_ERRORS, e);
	endtask
	task automatic t_errors();
		errchk(1, 16'h0008, 16'h0001, 16'h0030);
		errchk(1, 16'h0004, 16'h0001, 16'h0050);
		errchk(0, 16'h000C, 16'h0001, 16'h0051);
		errchk(0, 16'h0000, 16'h0000, 16'h0056);
		errchk(3, 16'h0000, 16'h0001, 16'h4056);
		errchk(2, 16'h0006, 16'h0005, 16'h4256);
	endtask
	task automatic print_verdict();
		if (err_count == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// main sequence after a 16 cycle reset
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		t_ready();
		t_up_once();
		t_down();
		t_repeat();
		t_diff();
		t_fault();
		t_fast();
		t_errors();
		print_verdict();
	end
	// watchdog: the tests need about 2700 cycles, mostly the fast filter
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		print_verdict();
	end
endmodule
